// ---- common/fdsr_pkg.sv ----
// constants and types shared by the fault detection and security reset block
`default_nettype none
package fdsr_pkg;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned CODE_W      = 7;
  localparam int unsigned KEY_W       = 128;
  localparam int unsigned NVM_W       = 32;
  localparam int unsigned MEM_AW      = 4;
  localparam int unsigned CLK_MHZ     = 100;
  // bus handshake timeout
  localparam int unsigned HS_TIMEOUT_NS   = 640;
  localparam int unsigned HS_TIMEOUT_CYC  = (HS_TIMEOUT_NS * CLK_MHZ) / 1000;
  // length of the hold phase that ends the security reset sequence
  localparam int unsigned SRST_HOLD_NS    = 160;
  localparam int unsigned SRST_HOLD_CYC   = (SRST_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam logic [15:0] WDOG_RESET      = 16'hffff;
  localparam logic [KEY_W-1:0] KEY_DEFAULT = '0;
  localparam logic [15:0] LFSR_SEED       = 16'hace1;
  localparam logic [15:0] LFSR_TAPS       = 16'hb400;
  // alarm vector positions
  localparam int unsigned AL_CPU      = 0;
  localparam int unsigned AL_MEM      = 1;
  localparam int unsigned AL_ROM      = 2;
  localparam int unsigned AL_PROBE    = 3;
  localparam int unsigned AL_BUS      = 4;
  localparam int unsigned AL_WDOG     = 5;
  localparam int unsigned AL_FLOW     = 6;
  localparam int unsigned AL_CIPHER   = 7;
  localparam int unsigned AL_NVM      = 8;
  localparam int unsigned AL_W        = 9;
  typedef enum logic [1:0] {
    FDSR_RUN,
    FDSR_CLEAR,
    FDSR_HOLD
  } fdsr_state_t;
  typedef enum logic [1:0] {
    FDSR_NV_IDLE,
    FDSR_NV_SHADOW,
    FDSR_NV_COMMIT
  } fdsr_nv_state_t;
endpackage : fdsr_pkg
`default_nettype wire

// ---- hdl/fdsr_top.sv ----
// fault, tamper and integrity detection with security reset sequencing
`timescale 1ns/1ns
`default_nettype none
module fdsr_top (
  input  wire logic                         clk_sys_i,
  input  wire logic                         rst_n_i,
  input  wire logic                         cpu_done_i,
  input  wire logic [fdsr_pkg::DATA_W-1:0]  cpu_a_res_i,
  input  wire logic [fdsr_pkg::DATA_W-1:0]  cpu_b_res_i,
  input  wire logic                         mem_rd_valid_i,
  input  wire logic [1:0]                   mem_src_i,
  input  wire logic [fdsr_pkg::DATA_W-1:0]  mem_rd_data_i,
  input  wire logic [fdsr_pkg::CODE_W-1:0]  mem_rd_code_i,
  input  wire logic                         rom_scan_done_i,
  input  wire logic [fdsr_pkg::DATA_W-1:0]  rom_scan_code_i,
  input  wire logic [fdsr_pkg::DATA_W-1:0]  rom_ref_code_i,
  input  wire logic                         probe_alarm_i,
  input  wire logic                         bus_req_i,
  input  wire logic                         bus_ack_i,
  input  wire logic                         wdog_kick_i,
  input  wire logic [15:0]                  wdog_load_i,
  input  wire logic                         chkpt_wr_i,
  input  wire logic [15:0]                  chkpt_data_i,
  input  wire logic [15:0]                  chkpt_expect_i,
  input  wire logic                         cipher_done_i,
  input  wire logic [fdsr_pkg::DATA_W-1:0]  cipher_in_i,
  input  wire logic [fdsr_pkg::DATA_W-1:0]  cipher_inv_i,
  input  wire logic                         startup_done_i,
  input  wire logic                         selftest_req_i,
  input  wire logic                         nv_wr_req_i,
  input  wire logic [fdsr_pkg::NVM_W-1:0]   nv_wr_data_i,
  input  wire logic                         nv_prog_ok_i,
  input  wire logic                         nv_prog_fail_i,
  output logic [fdsr_pkg::DATA_W-1:0]       mem_corr_data_o,
  output logic                              mem_corr_valid_o,
  output logic                              cpu_halt_o,
  output logic                              sec_reset_req_o,
  output logic                              cop_reset_o,
  output logic [fdsr_pkg::KEY_W-1:0]        key_o,
  output logic                              mem_fill_we_o,
  output logic [fdsr_pkg::MEM_AW-1:0]       mem_fill_addr_o,
  output logic [15:0]                       mem_fill_data_o,
  output logic [fdsr_pkg::AL_W-1:0]         alarm_cause_o,
  output logic                              selftest_busy_o,
  output logic                              selftest_pass_o,
  output logic                              nv_prog_o,
  output logic [fdsr_pkg::NVM_W-1:0]        nv_prog_data_o,
  output logic                              nv_shadow_valid_o,
  output logic [15:0]                       chkpt_o
);

  // pins from other domains are synchronised
  logic [1:0] probe_sync_reg;
  logic [1:0] nvok_sync_reg;
  logic [1:0] nvfail_sync_reg;
  wire probe_s  = probe_sync_reg[1];
  wire nvok_s   = nvok_sync_reg[1];
  wire nvfail_s = nvfail_sync_reg[1];

  // hamming(38,32) plus overall parity: syndrome over data and check bits
  function automatic logic [5:0] syn_calc(input logic [31:0] d, input logic [5:0] c);
    logic [5:0] s;
    logic [5:0] pos;
    int unsigned j;
    s = c;
    pos = 6'h00;
    j = 0;
    for (int unsigned p = 1; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        pos = 6'(p);
        if (d[j]) begin
          s = s ^ pos;
        end
        j++;
      end
    end
    return s;
  endfunction : syn_calc

  // data bit index addressed by a codeword position; 6'h3f when position is a check bit
  function automatic logic [5:0] pos_to_bit(input logic [5:0] pos);
    logic [5:0] r;
    int unsigned j;
    r = 6'h3f;
    j = 0;
    for (int unsigned p = 1; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (6'(p) == pos) begin
          r = 6'(j);
        end
        j++;
      end
    end
    return r;
  endfunction : pos_to_bit

  wire [5:0] mem_syn    = syn_calc(mem_rd_data_i, mem_rd_code_i[5:0]);
  wire       mem_par    = ^{mem_rd_data_i, mem_rd_code_i};
  wire       err_single = (mem_syn != 6'h00) && mem_par;
  wire       err_double = (mem_syn != 6'h00) && !mem_par;
  wire       src_nvm    = (mem_src_i == 2'h2);
  wire [5:0] flip_bit   = pos_to_bit(mem_syn);
  wire [31:0] flip_mask = (flip_bit == 6'h3f) ? 32'h0 : (32'h1 << flip_bit[4:0]);
  wire       mem_bad    = mem_rd_valid_i && (err_double || (err_single && !src_nvm));
  wire [31:0] corr_data = (err_single && src_nvm) ? (mem_rd_data_i ^ flip_mask)
                                                  : mem_rd_data_i;

  // alarm sources
  logic [15:0] wdog_reg;
  logic [$clog2(fdsr_pkg::HS_TIMEOUT_CYC+1)-1:0] hs_cnt_reg;
  logic        bus_busy_reg;
  logic        st_inject_reg;
  wire cpu_miss  = cpu_done_i && (cpu_a_res_i != cpu_b_res_i);
  wire rom_miss  = rom_scan_done_i && (rom_scan_code_i != rom_ref_code_i);
  wire hs_tmo    = bus_busy_reg &&
                   (hs_cnt_reg == ($clog2(fdsr_pkg::HS_TIMEOUT_CYC+1))'(fdsr_pkg::HS_TIMEOUT_CYC));
  wire wdog_tmo  = (wdog_reg == 16'h0000);
  wire flow_miss = chkpt_wr_i && (chkpt_data_i != chkpt_expect_i);
  wire ciph_miss = cipher_done_i && (cipher_in_i != cipher_inv_i);
  wire [fdsr_pkg::AL_W-1:0] alarm_vec = {nvfail_s, ciph_miss, flow_miss, wdog_tmo, hs_tmo,
                                         probe_s, rom_miss, mem_bad, cpu_miss};
  wire any_alarm = (|alarm_vec) && !st_inject_reg;

  // security reset sequencer
  fdsr_pkg::fdsr_state_t state_reg;
  fdsr_pkg::fdsr_state_t state_next;
  logic [fdsr_pkg::MEM_AW-1:0] fill_cnt_reg;
  logic [7:0]  hold_cnt_reg;
  logic [15:0] lfsr_reg;
  wire fill_last = (fill_cnt_reg == {fdsr_pkg::MEM_AW{1'b1}});
  wire hold_last = (hold_cnt_reg == 8'(fdsr_pkg::SRST_HOLD_CYC - 1));
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      fdsr_pkg::FDSR_RUN:   if (any_alarm) state_next = fdsr_pkg::FDSR_CLEAR;
      fdsr_pkg::FDSR_CLEAR: if (fill_last) state_next = fdsr_pkg::FDSR_HOLD;
      fdsr_pkg::FDSR_HOLD:  if (hold_last) state_next = fdsr_pkg::FDSR_RUN;
      default:              state_next = fdsr_pkg::FDSR_RUN;
    endcase
  end
  wire in_srst = (state_reg != fdsr_pkg::FDSR_RUN);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      probe_sync_reg  <= 2'h0;
      nvok_sync_reg   <= 2'h0;
      nvfail_sync_reg <= 2'h0;
      state_reg       <= fdsr_pkg::FDSR_RUN;
      fill_cnt_reg    <= '0;
      hold_cnt_reg    <= 8'h00;
      lfsr_reg        <= fdsr_pkg::LFSR_SEED;
    end else begin
      probe_sync_reg  <= {probe_sync_reg[0], probe_alarm_i};
      nvok_sync_reg   <= {nvok_sync_reg[0], nv_prog_ok_i};
      nvfail_sync_reg <= {nvfail_sync_reg[0], nv_prog_fail_i};
      state_reg       <= state_next;
      fill_cnt_reg    <= (state_reg == fdsr_pkg::FDSR_CLEAR) ? fill_cnt_reg + 1'b1 : '0;
      hold_cnt_reg    <= (state_reg == fdsr_pkg::FDSR_HOLD) ? hold_cnt_reg + 8'h01 : 8'h00;
      lfsr_reg        <= {lfsr_reg[14:0], ^(lfsr_reg & fdsr_pkg::LFSR_TAPS)};
    end
  end

  // outputs of the reset sequence; request, halt and resets raised and key cleared in the edge that sees the alarm, fill one edge later
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sec_reset_req_o <= 1'b0;
      cpu_halt_o      <= 1'b0;
      cop_reset_o     <= 1'b0;
      key_o           <= fdsr_pkg::KEY_DEFAULT;
      mem_fill_we_o   <= 1'b0;
      mem_fill_addr_o <= '0;
      mem_fill_data_o <= 16'h0000;
      alarm_cause_o   <= '0;
    end else begin
      sec_reset_req_o <= (state_next != fdsr_pkg::FDSR_RUN);
      cpu_halt_o      <= (state_next != fdsr_pkg::FDSR_RUN);
      cop_reset_o     <= (state_next != fdsr_pkg::FDSR_RUN);
      if (state_next != fdsr_pkg::FDSR_RUN) begin
        key_o <= fdsr_pkg::KEY_DEFAULT;
      end
      mem_fill_we_o   <= (state_reg == fdsr_pkg::FDSR_CLEAR);
      mem_fill_addr_o <= fill_cnt_reg;
      mem_fill_data_o <= lfsr_reg;
      if (state_reg == fdsr_pkg::FDSR_RUN && any_alarm) begin
        alarm_cause_o <= alarm_vec;
      end
    end
  end

  // bus handshake monitor
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_busy_reg <= 1'b0;
      hs_cnt_reg   <= '0;
    end else if (in_srst || bus_ack_i) begin
      bus_busy_reg <= 1'b0;
      hs_cnt_reg   <= '0;
    end else if (bus_req_i || bus_busy_reg) begin
      bus_busy_reg <= 1'b1;
      hs_cnt_reg   <= hs_tmo ? hs_cnt_reg : hs_cnt_reg + 1'b1;
    end
  end

  // watchdog, checkpoint and self-test
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wdog_reg        <= fdsr_pkg::WDOG_RESET;
      chkpt_o         <= 16'h0000;
      st_inject_reg   <= 1'b0;
      selftest_busy_o <= 1'b0;
      selftest_pass_o <= 1'b0;
    end else begin
      if (in_srst || wdog_kick_i) begin
        wdog_reg <= in_srst ? fdsr_pkg::WDOG_RESET : wdog_load_i;
      end else if (!wdog_tmo) begin
        wdog_reg <= wdog_reg - 16'h0001;
      end
      if (chkpt_wr_i) begin
        chkpt_o <= chkpt_data_i;
      end
      // self-test: sources stay live but are kept from the reset path for one check cycle
      st_inject_reg <= selftest_req_i && startup_done_i && !in_srst && !st_inject_reg;
      selftest_busy_o <= selftest_req_i && startup_done_i && !in_srst && !st_inject_reg;
      if (st_inject_reg) begin
        selftest_pass_o <= !probe_s && !wdog_tmo && !hs_tmo;
      end
    end
  end

  // corrected memory read path
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_corr_data_o  <= '0;
      mem_corr_valid_o <= 1'b0;
    end else begin
      mem_corr_data_o  <= corr_data;
      mem_corr_valid_o <= mem_rd_valid_i && !mem_bad && !in_srst;
    end
  end

  // tearing-safe nonvolatile write: data shadowed first, committed only on completion
  fdsr_pkg::fdsr_nv_state_t nv_state_reg;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nv_state_reg      <= fdsr_pkg::FDSR_NV_IDLE;
      nv_prog_o         <= 1'b0;
      nv_prog_data_o    <= '0;
      nv_shadow_valid_o <= 1'b0;
    end else begin
      case (nv_state_reg)
        fdsr_pkg::FDSR_NV_IDLE: begin
          if (nv_wr_req_i && !in_srst) begin
            nv_prog_data_o    <= nv_wr_data_i;
            nv_shadow_valid_o <= 1'b1;
            nv_state_reg      <= fdsr_pkg::FDSR_NV_SHADOW;
          end
        end
        fdsr_pkg::FDSR_NV_SHADOW: begin
          nv_prog_o    <= 1'b1;
          nv_state_reg <= fdsr_pkg::FDSR_NV_COMMIT;
        end
        fdsr_pkg::FDSR_NV_COMMIT: begin
          if (nvok_s) begin
            nv_prog_o         <= 1'b0;
            nv_shadow_valid_o <= 1'b0;
            nv_state_reg      <= fdsr_pkg::FDSR_NV_IDLE;
          end else if (nvfail_s || in_srst) begin
            nv_prog_o    <= 1'b0;
            nv_state_reg <= fdsr_pkg::FDSR_NV_IDLE;
          end
        end
        default: nv_state_reg <= fdsr_pkg::FDSR_NV_IDLE;
      endcase
    end
  end

endmodule : fdsr_top
`default_nettype wire

// ---- bench/fdsr_checker.sv ----
// concurrent checks on the ports of the fault detection block
`timescale 1ns/1ns
`default_nettype none
module fdsr_checker (
  input wire logic                         clk_sys_i,
  input wire logic                         rst_n_i,
  input wire logic                         cpu_done_i,
  input wire logic [fdsr_pkg::DATA_W-1:0]  cpu_a_res_i,
  input wire logic [fdsr_pkg::DATA_W-1:0]  cpu_b_res_i,
  input wire logic                         probe_alarm_i,
  input wire logic                         bus_req_i,
  input wire logic                         bus_ack_i,
  input wire logic                         mem_corr_valid_o,
  input wire logic                         cpu_halt_o,
  input wire logic                         sec_reset_req_o,
  input wire logic                         cop_reset_o,
  input wire logic [fdsr_pkg::KEY_W-1:0]   key_o,
  input wire logic                         mem_fill_we_o,
  input wire logic [fdsr_pkg::MEM_AW-1:0]  mem_fill_addr_o,
  input wire logic [fdsr_pkg::AL_W-1:0]    alarm_cause_o
);
  logic [7:0] req_cnt_reg;
  logic [7:0] bus_wait_reg;
  // saturating counts of reset request length and of an unanswered bus request
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_cnt_reg  <= 8'h00;
      bus_wait_reg <= 8'h00;
    end else begin
      req_cnt_reg  <= !sec_reset_req_o ? 8'h00 : req_cnt_reg + {7'h0, req_cnt_reg != 8'hff};
      bus_wait_reg <= !(bus_req_i && !bus_ack_i) ? 8'h00 :
                      bus_wait_reg + {7'h0, bus_wait_reg != 8'hff};
    end
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_start;
    $rose(sec_reset_req_o);
  endsequence
  sequence s_fill0;
    mem_fill_we_o && mem_fill_addr_o == 4'h0;
  endsequence
  a_cpu_mis_reset: assert property (
    cpu_done_i && cpu_a_res_i != cpu_b_res_i && !sec_reset_req_o
    |=> sec_reset_req_o && alarm_cause_o[fdsr_pkg::AL_CPU]) else $error("cpu miscompare missed");
  a_halt_cop_reset: assert property (sec_reset_req_o |-> cpu_halt_o && cop_reset_o)
    else $error("halt or coprocessor reset missing");
  a_key_cleared: assert property (cop_reset_o && $past(cop_reset_o)
    |-> key_o == fdsr_pkg::KEY_DEFAULT) else $error("key not cleared");
  a_fill_start: assert property (s_start |=> s_fill0) else $error("fill did not start");
  a_fill_step: assert property (mem_fill_we_o && mem_fill_addr_o != 4'hf
    |=> mem_fill_we_o && mem_fill_addr_o == $past(mem_fill_addr_o) + 4'h1) else $error("fill gap");
  a_req_sticky: assert property ($fell(sec_reset_req_o) |-> req_cnt_reg >= 8'd31)
    else $error("reset request ended early");
  a_bus_timeout: assert property (bus_wait_reg == 8'd70 |-> alarm_cause_o[fdsr_pkg::AL_BUS])
    else $error("bus timeout missed");
  a_probe_halt: assert property ($rose(probe_alarm_i) && !sec_reset_req_o
    |-> ##[1:4] (cpu_halt_o && alarm_cause_o[fdsr_pkg::AL_PROBE])) else $error("probe missed");
  a_corr_quiet: assert property (sec_reset_req_o && $past(sec_reset_req_o)
    |-> !mem_corr_valid_o) else $error("read data during reset");
endmodule : fdsr_checker
`default_nettype wire

// ---- bench/fdsr_partner.sv ----
// far side model: bus target and nonvolatile programming unit
`timescale 1ns/1ns
`default_nettype none
module fdsr_partner (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        bus_req_i,
  input  wire logic [7:0]  ack_delay_i,
  input  wire logic        nv_prog_i,
  input  wire logic        nv_fail_i,
  output logic             bus_ack_o,
  output logic             nv_ok_o,
  output logic             nv_fail_o
);
  logic [7:0] wait_reg;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_reg  <= 8'h00;
      bus_ack_o <= 1'b0;
      nv_ok_o   <= 1'b0;
      nv_fail_o <= 1'b0;
    end else begin
      wait_reg  <= (bus_req_i || nv_prog_i) ? wait_reg + 8'h01 : 8'h00;
      // a long delay lets the bus monitor time out
      bus_ack_o <= bus_req_i && wait_reg == ack_delay_i;
      nv_ok_o   <= nv_prog_i && wait_reg == 8'h03 && !nv_fail_i;
      nv_fail_o <= nv_prog_i && wait_reg == 8'h03 && nv_fail_i;
    end
  end
endmodule : fdsr_partner
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking bench for the fault detection and security reset block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk_sys_i, rst_n_i, cpu_done_i, mem_rd_valid_i, rom_scan_done_i, probe_alarm_i;
  logic bus_req_i, bus_ack_i, wdog_kick_i, chkpt_wr_i, cipher_done_i, startup_done_i;
  logic selftest_req_i, nv_wr_req_i, nv_prog_ok_i, nv_prog_fail_i, nv_fail, req_d;
  logic [31:0] cpu_a_res_i, cpu_b_res_i, mem_rd_data_i, rom_scan_code_i, rom_ref_code_i;
  logic [31:0] cipher_in_i, cipher_inv_i, nv_wr_data_i, mem_corr_data_o, nv_prog_data_o;
  logic [15:0] wdog_load_i, chkpt_data_i, chkpt_expect_i, mem_fill_data_o, chkpt_o;
  logic [127:0] key_o;
  logic [8:0]   alarm_cause_o;
  logic [7:0]   ack_delay;
  logic [6:0]   mem_rd_code_i;
  logic [3:0]   mem_fill_addr_o;
  logic [1:0]   mem_src_i;
  logic mem_corr_valid_o, cpu_halt_o, sec_reset_req_o, cop_reset_o, mem_fill_we_o;
  logic selftest_busy_o, selftest_pass_o, nv_prog_o, nv_shadow_valid_o;
  logic [31:0] q[$];
  int seed = 32'h3c42;
  int miscompares, n_checks;
  fdsr_top u_fdsr_top (.*);
  fdsr_partner u_fdsr_partner (.clk_sys_i, .rst_n_i, .bus_req_i, .ack_delay_i(ack_delay),
    .nv_prog_i(nv_prog_o), .nv_fail_i(nv_fail), .bus_ack_o(bus_ack_i),
    .nv_ok_o(nv_prog_ok_i), .nv_fail_o(nv_prog_fail_i));
  always #5 clk_sys_i = ~clk_sys_i;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // check bits over a 38-bit codeword, data in the non-power positions
  function automatic logic [6:0] enc(input logic [31:0] d);
    logic [6:0] c;
    int k;
    c = '0;
    k = 0;
    for (int p = 3; p <= 38; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int b = 0; b < 6; b++) c[b] = c[b] ^ (p[b] & d[k]);
        k++;
      end
    end
    c[6] = ^{d, c[5:0]};
    return c;
  endfunction : enc
  task automatic drop;
    {cpu_done_i, mem_rd_valid_i, rom_scan_done_i, wdog_kick_i, chkpt_wr_i, cipher_done_i,
     nv_wr_req_i, selftest_req_i} <= '0;
  endtask : drop
  task automatic rd(input logic [1:0] s, input logic [31:0] d, input logic [31:0] f);
    mem_src_i      <= s;
    mem_rd_data_i  <= d ^ f;
    mem_rd_code_i  <= enc(d);
    mem_rd_valid_i <= 1'b1;
    tick(1);
    drop();
    tick(1);
  endtask : rd
  // one alarm source per call, bit w of the strobe vector matches the cause position
  task automatic fire(input int w);
    logic [31:0] v;
    v = $random(seed);
    rst_n_i <= 1'b0;
    tick(2);
    rst_n_i <= 1'b1;
    {cpu_a_res_i, rom_scan_code_i, cipher_in_i, mem_rd_data_i} <= {v, v, v, v ^ 32'h3};
    {cpu_b_res_i, rom_ref_code_i, cipher_inv_i, nv_wr_data_i} <= {~v, ~v, ~v, v};
    {chkpt_data_i, chkpt_expect_i, wdog_load_i} <= {v[15:0], ~v[15:0], 16'h0020};
    {mem_src_i, mem_rd_code_i, nv_fail, ack_delay} <= {2'b00, enc(v), 1'b1, 8'd200};
    tick(1);
    q.push_back(32'h1 << w);
    {nv_wr_req_i, cipher_done_i, chkpt_wr_i, wdog_kick_i, bus_req_i, probe_alarm_i,
     rom_scan_done_i, mem_rd_valid_i, cpu_done_i} <= 9'h1 << w;
    tick(1);
    drop();
    for (int i = 0; i < 300 && sec_reset_req_o !== 1'b1; i++) tick(1);
    probe_alarm_i <= 1'b0;
    for (int i = 0; i < 100 && sec_reset_req_o === 1'b1; i++) tick(1);
    bus_req_i <= 1'b0;
    $display("alarm test %0d done", w);
  endtask : fire
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  // each read result or reset entry is compared with the oldest note
  always @(posedge clk_sys_i) begin
    if (mem_corr_valid_o === 1'b1 || (sec_reset_req_o === 1'b1 && req_d !== 1'b1)) begin
      if (q.size() == 0) chk(32'h0, 32'h1);
      else chk(mem_corr_valid_o === 1'b1 ? mem_corr_data_o : {23'h0, alarm_cause_o},
               q.pop_front());
    end
    req_d <= sec_reset_req_o;
  end
  initial begin
    #300000;
    miscompares++;
    print_verdict();
  end
  initial begin
    logic [31:0] v, f;
    {clk_sys_i, rst_n_i, cpu_done_i, mem_rd_valid_i, rom_scan_done_i, probe_alarm_i, bus_req_i,
     wdog_kick_i, chkpt_wr_i, cipher_done_i, startup_done_i, selftest_req_i, nv_wr_req_i,
     nv_fail, cpu_a_res_i, cpu_b_res_i, mem_rd_data_i, rom_scan_code_i, rom_ref_code_i,
     cipher_in_i, cipher_inv_i, nv_wr_data_i, wdog_load_i, chkpt_data_i, chkpt_expect_i,
     mem_rd_code_i, mem_src_i, ack_delay} = '0;
    tick(2);
    rst_n_i <= 1'b1;
    tick(1);
    {cpu_done_i, rom_scan_done_i, cipher_done_i, chkpt_wr_i} <= 4'hf;
    tick(1);
    drop();
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      f = $random(seed);
      q.push_back(v);
      rd(2'(i), v, 32'h0);
      q.push_back(v);
      rd(2'd2, v, 32'h1 << f[4:0]);
    end
    $display("read test done");
    ack_delay <= 8'd2;
    bus_req_i <= 1'b1;
    for (int i = 0; i < 20 && bus_ack_i !== 1'b1; i++) tick(1);
    bus_req_i <= 1'b0;
    nv_wr_data_i <= v;
    nv_wr_req_i  <= 1'b1;
    tick(1);
    drop();
    for (int i = 0; i < 20 && nv_prog_o !== 1'b1; i++) tick(1);
    chk(nv_prog_data_o, v);
    chk({31'h0, nv_shadow_valid_o}, 32'h1);
    for (int i = 0; i < 40 && nv_prog_o === 1'b1; i++) tick(1);
    startup_done_i <= 1'b1;
    tick(1);
    selftest_req_i <= 1'b1;
    tick(1);
    drop();
    for (int i = 0; i < 20 && selftest_busy_o !== 1'b1; i++) tick(1);
    tick(2);
    chk({31'h0, selftest_pass_o}, 32'h1);
    // matching checkpoint write: no alarm, value must show on the checkpoint output
    {chkpt_data_i, chkpt_expect_i} <= {2{v[15:0]}};
    chkpt_wr_i <= 1'b1;
    tick(1);
    drop();
    tick(1);
    chk({16'h0, chkpt_o}, {16'h0, v[15:0]});
    $display("bus nvm selftest done");
    for (int w = 0; w < 9; w++) fire(w);
    chk(32'(q.size()), 32'h0);
    print_verdict();
  end
endmodule : tb_top
bind fdsr_top fdsr_checker u_fdsr_checker (.*);
`default_nettype wire
